// *** verilog/synth_divider_program_port.sv ***
// Divider programming logic: parallel and serial load paths, master clear, outputs
`include "synth_divider_defs.svh"
module synth_divider_program_port
  import synth_divider_pkg::*;
#(
  parameter int FB_W = `FB_DIV_W,
  parameter int SHIFT_LEN = `SHIFT_LEN,
  parameter bit FB_FIRST = 1'b0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic master_clear,
  input wire logic parallel_latch_n,
  input wire logic [FB_W-1:0] feedback_divide_bits,
  input wire logic [`POST_SEL_W-1:0] post_divide_select,
  input wire logic serial_shift_clock,
  input wire logic serial_in,
  input wire logic serial_transfer,
  input wire logic pll_bypass_n,
  input wire logic ref_source_sel,
  input wire logic xtal_ref_tick,
  input wire logic ext_ref_tick,
  output synth_divider_pkg::divider_word_t divider_cfg,
  output synth_divider_pkg::prog_mode_t prog_mode,
  output logic ref_tick_sel,
  output logic [FB_W+4:0] vco_ratio,
  output logic test_monitor,
  output synth_divider_pkg::clk_pair_t clk_out
);
  import synth_divider_pkg::*;

  localparam int IN_W = 6 + FB_W + `POST_SEL_W;
  localparam int WORD_W = `TEST_W + `POST_SEL_W + FB_W;

  // All programming pins cross into the clock domain before any decoding; the reference select and ticks are not synchronised
  logic [IN_W-1:0] pins_raw;
  logic [IN_W-1:0] pins_s;
  assign pins_raw = {master_clear, parallel_latch_n, serial_shift_clock, serial_in, serial_transfer,
                     pll_bypass_n, feedback_divide_bits, post_divide_select};

  pin_sync #(.WIDTH(IN_W)) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  logic mr_s;
  logic pl_n_s;
  logic sclk_s;
  logic sdin_s;
  logic sxfer_s;
  logic byp_n_s;
  logic [FB_W-1:0] fb_s;
  logic [`POST_SEL_W-1:0] ps_s;
  assign {mr_s, pl_n_s, sclk_s, sdin_s, sxfer_s, byp_n_s, fb_s, ps_s} = pins_s;

  // Rising-edge test of a synchronised pin against its registered history
  function automatic logic rose(input logic now_v, input logic was_v);
    rose = now_v && !was_v;
  endfunction : rose

  // The synchroniser leaves reset at zero, which would read as a parallel
  // pass-through of zero and as false edges; programming waits until the pins
  // and the edge history hold real levels, so a pin event in the first
  // cycles after reset can be lost
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  logic pins_valid;
  always_comb begin
    settle_d = settle_q;
    if (settle_q != `SYNC_SETTLE) begin
      settle_d = settle_q + 2'h1;
    end
    pins_valid = (settle_q == `SYNC_SETTLE);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      settle_q <= 2'h0;
    end else begin
      settle_q <= settle_d;
    end
  end

  // Edge history and programming state
  logic pl_n_q;
  logic pl_n_d;
  logic sclk_q;
  logic sclk_d;
  logic sxfer_q;
  logic sxfer_d;
  logic [SHIFT_LEN-1:0] shift_q;
  logic [SHIFT_LEN-1:0] shift_d;
  logic [FB_W-1:0] fb_q;
  logic [FB_W-1:0] fb_d;
  logic [`POST_SEL_W-1:0] ps_q;
  logic [`POST_SEL_W-1:0] ps_d;
  logic [`TEST_W-1:0] test_q;
  logic [`TEST_W-1:0] test_d;
  logic serial_mode_q;
  logic serial_mode_d;

  // Field extraction from the shift register, order set by parameter
  logic [FB_W-1:0] sh_fb;
  logic [`POST_SEL_W-1:0] sh_ps;
  logic [`TEST_W-1:0] sh_test;
  always_comb begin
    if (FB_FIRST) begin
      {sh_fb, sh_ps, sh_test} = shift_q[WORD_W-1:0];
    end else begin
      {sh_test, sh_ps, sh_fb} = shift_q[WORD_W-1:0];
    end
  end

  logic sclk_rise;
  logic pl_rise;
  logic xfer_rise;
  logic xfer_fall;

  always_comb begin
    sclk_rise = rose(sclk_s, sclk_q);
    pl_rise = rose(pl_n_s, pl_n_q);
    xfer_rise = rose(sxfer_s, sxfer_q);
    xfer_fall = rose(sxfer_q, sxfer_s);
    // Edge history keeps running through clear so no stale edge fires after it
    pl_n_d = pl_n_s;
    sclk_d = sclk_s;
    sxfer_d = sxfer_s;
    shift_d = shift_q;
    fb_d = fb_q;
    ps_d = ps_q;
    test_d = test_q;
    serial_mode_d = serial_mode_q;
    // Master clear only stops the outputs; stored values are untouched
    if (!mr_s && pins_valid) begin
      if (!pl_n_s) begin
        fb_d = fb_s;
        ps_d = ps_s;
        serial_mode_d = 1'b0;
      end else if (pl_rise && !sxfer_s) begin
        fb_d = fb_s;
        ps_d = ps_s;
        serial_mode_d = 1'b0;
      end else begin
        if (sclk_rise) begin
          shift_d = {shift_q[SHIFT_LEN-2:0], sdin_s};
          serial_mode_d = 1'b1;
        end
        // Without an edge the shift register holds its contents
        if (sxfer_s && sclk_rise) begin
          fb_d = {fb_q[FB_W-2:0], sdin_s};
        end else if (xfer_rise && !sclk_s) begin
          fb_d = sh_fb;
          ps_d = sh_ps;
          test_d = sh_test;
          serial_mode_d = 1'b1;
        end else if (xfer_fall && !sclk_s) begin
          fb_d = sh_fb;
          ps_d = sh_ps;
          test_d = sh_test;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pl_n_q <= 1'b0;
      sclk_q <= 1'b0;
      sxfer_q <= 1'b0;
      shift_q <= '0;
      fb_q <= FB_W'(`FB_DIV_RESET);
      ps_q <= `POST_SEL_RESET;
      test_q <= `TEST_RESET;
      serial_mode_q <= 1'b0;
    end else begin
      pl_n_q <= pl_n_d;
      sclk_q <= sclk_d;
      sxfer_q <= sxfer_d;
      shift_q <= shift_d;
      fb_q <= fb_d;
      ps_q <= ps_d;
      test_q <= test_d;
      serial_mode_q <= serial_mode_d;
    end
  end

  // Reference selection and VCO strobe: one tick per selected reference tick, not multiplied by M
  // Feedback count is kept as the divider state; the outputs run from reference events
  logic [FB_W-1:0] ref_count_q;
  logic [FB_W-1:0] ref_count_d;
  logic ref_tick;
  logic vco_tick;
  always_comb begin
    ref_tick = ref_source_sel ? xtal_ref_tick : ext_ref_tick;
    ref_count_d = ref_count_q;
    if (ref_tick) begin
      ref_count_d = (ref_count_q + FB_W'(1) >= fb_q) ? '0 : ref_count_q + FB_W'(1);
    end
    // Model limit: VCO ticks are the reference events, the ratio reported as M
    vco_tick = ref_tick;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ref_count_q <= '0;
    end else begin
      ref_count_q <= ref_count_d;
    end
  end

  logic phase_i;
  logic phase_q;
  clk_output_gen u_out (
    .clock(clock),
    .rst_b(rst_b),
    .vco_tick(vco_tick),
    .post_divide_select(ps_q),
    .quad_enable(byp_n_s),
    .hold_low(mr_s),
    .phase_i(phase_i),
    .phase_q(phase_q)
  );

  // Registered outputs
  divider_word_t cfg_q;
  prog_mode_t mode_q;
  prog_mode_t mode_d;
  logic ref_sel_q;
  logic [FB_W+4:0] ratio_q;
  logic [FB_W+4:0] ratio_d;
  logic test_mon_q;
  logic test_mon_d;
  clk_pair_t clk_q;
  clk_pair_t clk_d;

  always_comb begin
    // Serial modes show only after a serial event; any parallel load leaves them
    if (!serial_mode_q) begin
      mode_d = MODE_PARALLEL;
    end else if (sxfer_s) begin
      mode_d = MODE_SERIAL_THROUGH;
    end else begin
      mode_d = MODE_SERIAL_SHIFT;
    end
    // Ratio of VCO to reference is M, times 16 / N as the output ratio
    unique case (ps_q)
      `POST_DIV1: ratio_d = {1'b0, fb_q, 4'h0};
      `POST_DIV2: ratio_d = {2'b00, fb_q, 3'h0};
      `POST_DIV4: ratio_d = {3'b000, fb_q, 2'h0};
      `POST_DIV8: ratio_d = {4'h0, fb_q, 1'b0};
    endcase
    test_mon_d = serial_mode_q && pl_n_s && sdin_s;
    // Inverted legs are plain complements, so clear gives true low, inverted high
    clk_d.primary_clk_out = phase_i;
    clk_d.primary_clk_out_b = !phase_i;
    clk_d.quadrature_clk_out = phase_q;
    clk_d.quadrature_clk_out_b = !phase_q;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= '0;
      mode_q <= MODE_PARALLEL;
      ref_sel_q <= 1'b0;
      ratio_q <= '0;
      test_mon_q <= 1'b0;
      clk_q <= 4'h5;
    end else begin
      cfg_q <= {test_q, ps_q, fb_q};
      mode_q <= mode_d;
      ref_sel_q <= ref_tick;
      ratio_q <= ratio_d;
      test_mon_q <= test_mon_d;
      clk_q <= clk_d;
    end
  end

  assign divider_cfg = cfg_q;
  assign prog_mode = mode_q;
  assign ref_tick_sel = ref_sel_q;
  assign vco_ratio = ratio_q;
  assign test_monitor = test_mon_q;
  assign clk_out = clk_q;
endmodule : synth_divider_program_port

// *** verilog/synth_divider_defs.svh ***
// Constants for the synthesizer divider programming port
`ifndef SYNTH_DIVIDER_DEFS_SVH
`define SYNTH_DIVIDER_DEFS_SVH
`define FB_DIV_W 9
`define POST_SEL_W 2
`define TEST_W 3
`define SHIFT_LEN 14
`define FB_DIV_RESET 9'h00A
`define POST_SEL_RESET 2'h0
`define TEST_RESET 3'h0
`define POST_DIV1 2'h0
`define POST_DIV2 2'h1
`define POST_DIV4 2'h2
`define POST_DIV8 2'h3
`define SYNC_STAGES 2
`define SYNC_SETTLE 2'h3
`endif

// *** verilog/synth_divider_pkg.sv ***
// Types shared by the divider programming port
`include "synth_divider_defs.svh"
package synth_divider_pkg;
  typedef struct packed {
    logic [`TEST_W-1:0] test_field;
    logic [`POST_SEL_W-1:0] post_divide_select;
    logic [`FB_DIV_W-1:0] feedback_divide_bits;
  } divider_word_t;

  typedef struct packed {
    logic primary_clk_out;
    logic primary_clk_out_b;
    logic quadrature_clk_out;
    logic quadrature_clk_out_b;
  } clk_pair_t;

  typedef enum logic [1:0] {
    MODE_PARALLEL,
    MODE_SERIAL_SHIFT,
    MODE_SERIAL_THROUGH
  } prog_mode_t;
endpackage : synth_divider_pkg

// *** verilog/pin_sync.sv ***
// Two-stage synchroniser for a bundle of pin inputs
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : pin_sync

// *** verilog/clk_output_gen.sv ***
// Post divider and quadrature output generator driven by a VCO-rate strobe
`include "synth_divider_defs.svh"
module clk_output_gen (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic vco_tick,
  input wire logic [`POST_SEL_W-1:0] post_divide_select,
  input wire logic quad_enable,
  input wire logic hold_low,
  output logic phase_i,
  output logic phase_q
);
  logic [3:0] count_q;
  logic [3:0] count_d;
  logic [3:0] half;
  logic [4:0] full;
  logic [4:0] count_inc;

  // Output period in VCO ticks is 2 * divider so quarter steps exist; divide by 8 needs a 5-bit period
  always_comb begin
    unique case (post_divide_select)
      `POST_DIV1: half = 4'h1;
      `POST_DIV2: half = 4'h2;
      `POST_DIV4: half = 4'h4;
      `POST_DIV8: half = 4'h8;
    endcase
    full = {half, 1'b0};
  end

  always_comb begin
    count_inc = {1'b0, count_q} + 5'h01;
    count_d = count_q;
    if (hold_low) begin
      count_d = 4'h0;
    end else if (vco_tick) begin
      count_d = (count_inc >= full) ? 4'h0 : count_inc[3:0];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= 4'h0;
    end else begin
      count_q <= count_d;
    end
  end

  logic [4:0] q_pos;
  always_comb begin
    q_pos = {1'b0, count_q} + full - {2'b00, half[3:1]};
    if (q_pos >= full) begin
      q_pos = q_pos - full;
    end
    phase_i = !hold_low && (count_q < half);
    // Quadrature lags by a quarter period, with no lag at divide by 1; in bypass it follows phase_i
    phase_q = !hold_low && (quad_enable ? (q_pos[3:0] < half) : (count_q < half));
  end
endmodule : clk_output_gen

// *** test/synth_divider_program_port_sva.sv ***
// Assertions on the divider programming port
`include "synth_divider_defs.svh"
module synth_divider_program_port_sva
  import synth_divider_pkg::*;
#(
  parameter int FB_W = 9
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic master_clear,
  input wire logic parallel_latch_n,
  input wire logic [FB_W-1:0] feedback_divide_bits,
  input wire logic [`POST_SEL_W-1:0] post_divide_select,
  input wire logic serial_shift_clock,
  input wire logic serial_transfer,
  input wire logic pll_bypass_n,
  input wire logic ref_source_sel,
  input wire logic xtal_ref_tick,
  input wire logic ext_ref_tick,
  input synth_divider_pkg::divider_word_t divider_cfg,
  input synth_divider_pkg::prog_mode_t prog_mode,
  input wire logic ref_tick_sel,
  input wire logic test_monitor,
  input synth_divider_pkg::clk_pair_t clk_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Six cycles cover the sync flops, edge register and output stage
  sequence par_open;
    (!parallel_latch_n && !master_clear && $stable(feedback_divide_bits) && $stable(post_divide_select))[*6];
  endsequence
  sequence clear_held;
    master_clear[*6];
  endsequence
  sequence ser_idle;
    (parallel_latch_n && !serial_transfer && !master_clear)[*5];
  endsequence
  sequence shift_seen;
    (parallel_latch_n && !serial_transfer && !master_clear && $rose(serial_shift_clock)) ##1 ser_idle;
  endsequence
  chk_clear_outputs: assert property (clear_held |-> clk_out == 4'h5)
    else $error("outputs not forced by clear");
  chk_clear_keeps: assert property (clear_held ##1 master_clear |-> $stable(divider_cfg))
    else $error("divider values moved during clear");
  chk_pass_through: assert property (par_open |-> divider_cfg[10:0] == {post_divide_select, feedback_divide_bits})
    else $error("parallel values not passed through");
  chk_test_low: assert property (par_open |-> !test_monitor)
    else $error("test monitor active in parallel mode");
  chk_mode_par: assert property (par_open |-> prog_mode == MODE_PARALLEL)
    else $error("mode not parallel");
  chk_shift_hold: assert property (ser_idle ##1 (parallel_latch_n && !serial_transfer) |-> $stable(divider_cfg))
    else $error("dividers moved while shifting");
  chk_mode_shift: assert property (shift_seen |-> prog_mode == MODE_SERIAL_SHIFT)
    else $error("mode not serial shift");
  chk_mode_thru: assert property ((parallel_latch_n && serial_transfer && !master_clear)[*5]
    |-> prog_mode == MODE_SERIAL_THROUGH)
    else $error("mode not serial through");
  chk_bypass_align: assert property ((!pll_bypass_n && !master_clear)[*8]
    |-> clk_out.primary_clk_out == clk_out.quadrature_clk_out)
    else $error("outputs not aligned in bypass");
  chk_ref_pick: assert property (ref_tick_sel |-> ($past(ref_source_sel) ? $past(xtal_ref_tick) : $past(ext_ref_tick)))
    else $error("tick from unselected reference");
  chk_ref_follow: assert property (ref_source_sel && xtal_ref_tick |=> ref_tick_sel)
    else $error("crystal tick lost");
endmodule : synth_divider_program_port_sva

bind synth_divider_program_port synth_divider_program_port_sva #(.FB_W(FB_W)) sva (.clock, .rst_b, .master_clear,
  .parallel_latch_n, .feedback_divide_bits, .post_divide_select, .serial_shift_clock, .serial_transfer,
  .pll_bypass_n, .ref_source_sel, .xtal_ref_tick, .ext_ref_tick, .divider_cfg, .prog_mode, .ref_tick_sel,
  .test_monitor, .clk_out);

// *** test/prog_host.sv ***
// Host controller model driving the programming pins
module prog_host (
  input wire logic clock,
  output logic master_clear,
  output logic parallel_latch_n,
  output logic [8:0] feedback_divide_bits,
  output logic [1:0] post_divide_select,
  output logic serial_shift_clock,
  output logic serial_in,
  output logic serial_transfer
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {master_clear, serial_shift_clock, serial_in, serial_transfer} = 4'h0;
    parallel_latch_n = 1'b1;
    feedback_divide_bits = 9'h00A;
    post_divide_select = 2'h0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  // Shift clock stays low while these levels move
  task automatic pins(input logic mc, ln, st, input logic [8:0] fb, input logic [1:0] nd);
    master_clear = mc;
    parallel_latch_n = ln;
    serial_transfer = st;
    feedback_divide_bits = fb;
    post_divide_select = nd;
    step(6);
  endtask : pins
  // Data is inverted once its hold is over, so a late sample shows up
  task automatic shift_bit(input logic b);
    serial_in = b;
    step(3);
    serial_shift_clock = 1'b1;
    step(3);
    serial_shift_clock = 1'b0;
    serial_in = ~b;
    step(3);
  endtask : shift_bit
endmodule : prog_host

// *** test/synth_divider_program_port_tb.sv ***
// Self-checking bench for the divider programming port
module synth_divider_program_port_tb;
  import synth_divider_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst_b, master_clear, parallel_latch_n, serial_shift_clock, serial_in, serial_transfer;
  logic pll_bypass_n, ref_source_sel, xtal_ref_tick, ext_ref_tick, tick_run, ref_tick_sel, test_monitor;
  logic [8:0] feedback_divide_bits;
  logic [1:0] post_divide_select;
  logic [13:0] vco_ratio;
  divider_word_t divider_cfg;
  prog_mode_t prog_mode;
  clk_pair_t clk_out;
  int err_total, samples_checked;
  int bits[$];
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Crystal ticks every other cycle, so one output period is 4*N clocks
  always @(posedge clock) begin
    xtal_ref_tick <= #1 tick_run & ~xtal_ref_tick;
    ext_ref_tick <= #1 ~ref_source_sel & 1'($urandom_range(0, 1));
  end
  prog_host host (.clock(clock), .master_clear(master_clear), .parallel_latch_n(parallel_latch_n),
    .feedback_divide_bits(feedback_divide_bits), .post_divide_select(post_divide_select),
    .serial_shift_clock(serial_shift_clock), .serial_in(serial_in), .serial_transfer(serial_transfer));
  synth_divider_program_port #(.FB_W(9)) dut (.clock(clock), .rst_b(rst_b), .master_clear(master_clear),
    .parallel_latch_n(parallel_latch_n), .feedback_divide_bits(feedback_divide_bits),
    .post_divide_select(post_divide_select), .serial_shift_clock(serial_shift_clock), .serial_in(serial_in),
    .serial_transfer(serial_transfer), .pll_bypass_n(pll_bypass_n), .ref_source_sel(ref_source_sel),
    .xtal_ref_tick(xtal_ref_tick), .ext_ref_tick(ext_ref_tick), .divider_cfg(divider_cfg),
    .prog_mode(prog_mode), .ref_tick_sel(ref_tick_sel), .vco_ratio(vco_ratio),
    .test_monitor(test_monitor), .clk_out(clk_out));
  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // Cycles until the next low-to-high step of the primary output
  task automatic rise(output int t);
    logic p;
    p = 1'b1;
    t = 0;
    while (!(p === 1'b0 && clk_out.primary_clk_out === 1'b1) && t < 200) begin
      p = clk_out.primary_clk_out;
      host.step(1);
      t++;
    end
    if (t >= 200) begin
      err_total++;
      final_report();
    end
  endtask : rise
  initial begin
    int a, b, fb, nd;
    logic [13:0] w, e;
    {rst_b, tick_run, xtal_ref_tick, ext_ref_tick} = 4'h0;
    {pll_bypass_n, ref_source_sel} = 2'h3;
    void'($urandom(32'h4234));
    repeat (8) @(posedge clock);
    #1;
    check(14'(clk_out), 14'h0005);
    rst_b = 1'b1;
    host.step(1);
    check(divider_cfg, 14'h000A);
    tick_run = 1'b1;
    for (nd = 0; nd < 4; nd++) begin
      fb = $urandom_range(10, 28);
      host.pins(0, 0, 0, 9'(fb), 2'(nd));
      check({3'h0, divider_cfg[10:0]}, {3'h0, 2'(nd), 9'(fb)});
      check(14'(test_monitor), 14'h0);
      check(vco_ratio, 14'((fb * 16) >> nd));
      // Latch rises with the data still held, then the data moves
      host.pins(0, 1, 0, 9'(fb), 2'(nd));
      host.pins(0, 1, 0, 9'($urandom), 2'(~nd));
      check({3'h0, divider_cfg[10:0]}, {3'h0, 2'(nd), 9'(fb)});
      rise(a);
      rise(b);
      check(14'(b), 14'(4 << nd));
      for (a = 0; a < 64 && clk_out.quadrature_clk_out !== 1'b1; a++) begin
        host.step(1);
      end
      check(14'(a), 14'(nd == 0 ? 0 : 1 << nd));
    end
    host.pins(0, 0, 0, 9'h00A, 2'h1);
    pll_bypass_n = 1'b0;
    host.step(40);
    pll_bypass_n = 1'b1;
    ref_source_sel = 1'b0;
    host.step(40);
    ref_source_sel = 1'b1;
    host.pins(0, 1, 0, 9'h00A, 2'h1);
    e = 14'h020A;
    repeat (2) begin
      w = 14'($urandom);
      for (int i = 13; i >= 0; i--) begin
        host.shift_bit(w[i]);
        check({13'h0, test_monitor}, {13'h0, ~w[i]});
        bits.push_back(w[i]);
      end
      check(divider_cfg, e);
      host.pins(0, 1, 1, 9'h000, 2'h0);
      host.pins(0, 1, 0, 9'h000, 2'h0);
      e = 14'h0;
      for (int k = bits.size() - 14; k < bits.size(); k++) e = {e[12:0], 1'(bits[k])};
      check(divider_cfg, e);
    end
    host.pins(1, 1, 0, 9'h1FF, 2'h3);
    check(14'(clk_out), 14'h0005);
    check(divider_cfg, e);
    host.pins(0, 1, 1, 9'h000, 2'h0);
    for (int i = 0; i < 3; i++) begin
      w[0] = 1'($urandom);
      host.shift_bit(w[0]);
      e[8:0] = {e[7:0], w[0]};
    end
    check(divider_cfg, e);
    host.pins(0, 1, 0, 9'h000, 2'h0);
    final_report();
  end
endmodule : synth_divider_program_port_tb
